//--- nsc_pkg.sv
// Package: shared constants for the NMI source control block
// Function
// RQ1 - Set bit 7 on system error if enabled
// RQ2 - Control bit 2 high clears and blocks bit 7
// RQ3 - Set bit 6 on channel check if enabled
// RQ4 - Control bit 3 high clears and blocks bit 6
// RQ5 - Bit 5 reads live counter 2 output
// RQ6 - Bit 4 toggles after each refresh cycle
// RQ7 - Speaker follows counter 2 when bit 1 set
// RQ8 - Control bit 0 gates timer counter 2
// RQ9 - Software writes zero to bits 7 to 4
// RQ10 - Port 070h bit 7 masks NMI, resets to 1
// RQ11 - Port 070h accesses forwarded, reads skip RTC strobes
// RQ12 - Port 070h write latches RTC index bits 6:0
// RQ13 - NMI level high while enabled source pending
// RQ14 - Handler reads 061h, clears, then toggles mask
// RQ15 - Processor sees NMI only on rising edge
// RQ16 - Software programs counter 2 before trusting bit 5
// RQ17 - Extended index bit 7 must mirror mask
// RQ18 - Status holds until cleared; NMI is masked OR
package nsc_pkg;
    // ==========================================================
    // Port addresses
    localparam logic [15:0] NSC_PORT_STATUS = 16'h0061;
    localparam logic [15:0] NSC_PORT_MASK = 16'h0070;
    // ==========================================================
    // Field positions of port 061h, and the mask bit of port 070h
    localparam int NSC_BIT_SERR_STS = 7;
    localparam int NSC_BIT_CHK_STS = 6;
    localparam int NSC_BIT_C2_OUT = 5;
    localparam int NSC_BIT_REFRESH = 4;
    localparam int NSC_BIT_CHK_DIS = 3;
    localparam int NSC_BIT_SERR_DIS = 2;
    localparam int NSC_BIT_SPK_EN = 1;
    localparam int NSC_BIT_C2_GATE = 0;
    localparam int NSC_BIT_MASK = 7;
    // ==========================================================
    // Reset values
    localparam logic [3:0] NSC_CTRL_RESET = 4'h0;
    localparam logic NSC_MASK_RESET = 1'b1;
    localparam logic [6:0] NSC_INDEX_RESET = 7'h00;
    // ==========================================================
    // Offsets of the host's own registers
    localparam logic [7:0] NSC_REG_CMD = 8'h00;
    localparam logic [7:0] NSC_REG_RESULT = 8'h04;
    localparam logic [7:0] NSC_REG_STATUS = 8'h08;
    localparam logic [7:0] NSC_REG_CLEAR = 8'h0C;
    localparam logic [7:0] NSC_REG_ENABLE = 8'h10;
endpackage : nsc_pkg

//--- nsc_if.sv
// Interface: processor I/O port cycles and NMI line between the two ends
`timescale 1ns/10ps
interface nsc_if;
    logic io_req;
    logic io_write;
    logic [15:0] io_addr;
    logic [7:0] io_wdata;
    logic io_ack;
    logic [7:0] io_rdata;
    logic nmi;

    modport dev (input io_req, input io_write, input io_addr, input io_wdata,
        output io_ack, output io_rdata, output nmi);
    modport cpu (output io_req, output io_write, output io_addr, output io_wdata,
        input io_ack, input io_rdata, input nmi);
endinterface : nsc_if

//--- nsc_device.sv
// Device end: NMI source status, mask and RTC index logic
`timescale 1ns/10ps
module nsc_device (
    input wire logic aclk,
    input wire logic aresetn,
    nsc_if.dev bus,
    input wire logic serr_pulse,
    input wire logic chan_check,
    input wire logic counter2_out,
    input wire logic refresh_done,
    output logic speaker_out,
    output logic counter2_gate,
    output logic [6:0] rtc_standard_index,
    output logic isa_forward,
    output logic isa_forward_write,
    output logic rtc_chip_select_n,
    output logic rtc_address_latch_strobe
);
    // ==========================================================
    // Pin synchronisers: three stages, change taken when 2 and 3 agree
    // A pin pulse shorter than two clocks is filtered out
    logic [2:0] pin_raw;
    wire logic [2:0] pin_sync;
    logic serr_q, chk_q, c2_q;
    assign pin_raw = {counter2_out, chan_check, serr_pulse};
    assign serr_q = pin_sync[0];
    assign chk_q = pin_sync[1];
    assign c2_q = pin_sync[2];
    for (genvar p = 0; p < 3; p++) begin : g_sync
        logic [2:0] stage_q;
        logic level_q;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                stage_q <= 3'h0;
                level_q <= 1'b0;
            end else begin
                stage_q <= {stage_q[1:0], pin_raw[p]};
                if (stage_q[1] == stage_q[2]) level_q <= stage_q[2];
            end
        end
        assign pin_sync[p] = level_q;
    end

    // ==========================================================
    // Decode of one-cycle I/O requests
    logic wr_status, wr_mask, rd_mask;
    assign wr_status = bus.io_req && bus.io_write && bus.io_addr == nsc_pkg::NSC_PORT_STATUS;
    assign wr_mask = bus.io_req && bus.io_write && bus.io_addr == nsc_pkg::NSC_PORT_MASK;
    assign rd_mask = bus.io_req && !bus.io_write && bus.io_addr == nsc_pkg::NSC_PORT_MASK;

    // ==========================================================
    // Control bits of port 061h; bits 7:4 of writes ignored
    logic [3:0] ctrl_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= nsc_pkg::NSC_CTRL_RESET;
        end else if (wr_status) begin
            ctrl_q <= bus.io_wdata[3:0]; // [RQ9]
        end
    end

    // ==========================================================
    // Sticky source status; a disable bit holds it clear
    logic serr_sts_q, chk_sts_q, serr_prev_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serr_sts_q <= 1'b0;
            serr_prev_q <= 1'b0;
        end else begin
            serr_prev_q <= serr_q;
            if (ctrl_q[nsc_pkg::NSC_BIT_SERR_DIS]) begin
                serr_sts_q <= 1'b0; // [RQ2]
            end else if (serr_q && !serr_prev_q) begin
                serr_sts_q <= 1'b1; // [RQ1] [RQ18]
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chk_sts_q <= 1'b0;
        end else if (ctrl_q[nsc_pkg::NSC_BIT_CHK_DIS]) begin
            chk_sts_q <= 1'b0; // [RQ4]
        end else if (chk_q) begin
            chk_sts_q <= 1'b1; // [RQ3] [RQ18]
        end
    end

    // ==========================================================
    // Refresh toggle; the refresh generator is same-clock logic
    logic refresh_tgl_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refresh_tgl_q <= 1'b0;
        end else if (refresh_done) begin
            refresh_tgl_q <= !refresh_tgl_q; // [RQ6]
        end
    end

    // ==========================================================
    // Mask and RTC index at port 070h
    logic mask_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= nsc_pkg::NSC_MASK_RESET; // [RQ10]
            rtc_standard_index <= nsc_pkg::NSC_INDEX_RESET;
        end else if (wr_mask) begin
            mask_q <= bus.io_wdata[nsc_pkg::NSC_BIT_MASK]; // [RQ10]
            rtc_standard_index <= bus.io_wdata[6:0]; // [RQ12]
        end
    end

    // ==========================================================
    // Outputs, each from a flip-flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus.nmi <= 1'b0;
            speaker_out <= 1'b0;
            counter2_gate <= 1'b0;
        end else begin
            // Level, not pulse: handler must toggle the mask for a new edge
            bus.nmi <= !mask_q && (serr_sts_q || chk_sts_q); // [RQ13] [RQ18]
            speaker_out <= ctrl_q[nsc_pkg::NSC_BIT_SPK_EN] && c2_q; // [RQ7]
            counter2_gate <= ctrl_q[nsc_pkg::NSC_BIT_C2_GATE]; // [RQ8]
        end
    end

    // Port 070h accesses pass to ISA; RTC strobes only on writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            isa_forward <= 1'b0;
            isa_forward_write <= 1'b0;
            rtc_chip_select_n <= 1'b1;
            rtc_address_latch_strobe <= 1'b0;
        end else begin
            isa_forward <= wr_mask || rd_mask; // [RQ11]
            isa_forward_write <= wr_mask;
            rtc_chip_select_n <= !wr_mask; // [RQ11]
            rtc_address_latch_strobe <= wr_mask; // [RQ11]
        end
    end

    // One-cycle answer; 070h is write-only so it reads as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus.io_ack <= 1'b0;
            bus.io_rdata <= 8'h00;
        end else begin
            bus.io_ack <= bus.io_req;
            if (bus.io_req && !bus.io_write && bus.io_addr == nsc_pkg::NSC_PORT_STATUS) begin
                bus.io_rdata <= {serr_sts_q, chk_sts_q, c2_q, refresh_tgl_q, ctrl_q}; // [RQ5]
            end else begin
                bus.io_rdata <= 8'h00;
            end
        end
    end
endmodule : nsc_device

//--- nsc_host.sv
// Host end: AXI4-Lite register slave driving processor I/O cycles and NMI service
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
module nsc_host (
    input wire logic aclk,
    input wire logic aresetn,
    nsc_if.cpu bus,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic irq
);
    // ==========================================================
    // Own register map
    localparam logic [7:0] REG_CMD = nsc_pkg::NSC_REG_CMD; // [8]=write,[23:16]=port,[7:0]=data
    localparam logic [7:0] REG_RESULT = nsc_pkg::NSC_REG_RESULT; // [8]=busy,[7:0]=read data
    localparam logic [7:0] REG_STATUS = nsc_pkg::NSC_REG_STATUS; // [0]=nmi edge,[1]=io done
    localparam logic [7:0] REG_CLEAR = nsc_pkg::NSC_REG_CLEAR;
    localparam logic [7:0] REG_ENABLE = nsc_pkg::NSC_REG_ENABLE;

    typedef enum logic [1:0] {NSH_IDLE, NSH_REQ, NSH_WAIT} nsc_state_e;
    nsc_state_e state_q;
    logic [7:0] rdata_q;
    logic [1:0] sts_q, en_q;
    logic nmi_prev_q, aw_got_q, w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic do_write, io_done;
    // Byte lane 0 strobe kept with the data it qualifies
    logic cmd_lane_q;

    // ==========================================================
    // AXI4-Lite write: address and data in either order
    assign do_write = aw_got_q && w_got_q && !s_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            cmd_lane_q <= 1'b0;
            s_bvalid <= 1'b0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_wdata;
                cmd_lane_q <= s_wstrb[0];
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_bvalid <= 1'b1;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end
    assign s_awready = !aw_got_q && !s_bvalid;
    assign s_wready = !w_got_q && !s_bvalid;
    assign s_bresp = 2'h0;

    // ==========================================================
    // I/O cycle sequencer; new command while busy is dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= NSH_IDLE;
            bus.io_req <= 1'b0;
            bus.io_write <= 1'b0;
            bus.io_addr <= 16'h0000;
            bus.io_wdata <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            unique case (state_q)
                NSH_IDLE: begin
                    if (do_write && awaddr_q == REG_CMD && cmd_lane_q) begin
                        bus.io_req <= 1'b1;
                        bus.io_write <= wdata_q[8];
                        bus.io_addr <= {8'h00, wdata_q[23:16]};
                        bus.io_wdata <= wdata_q[7:0]; // [RQ9] [RQ14] [RQ17]
                        state_q <= NSH_REQ;
                    end
                end
                NSH_REQ: begin
                    bus.io_req <= 1'b0;
                    state_q <= NSH_WAIT;
                end
                NSH_WAIT: begin
                    if (bus.io_ack) begin
                        rdata_q <= bus.io_rdata;
                        state_q <= NSH_IDLE;
                    end
                end
            endcase
        end
    end
    assign io_done = state_q == NSH_WAIT && bus.io_ack;

    // ==========================================================
    // Interrupts: NMI on rising edge only, plus I/O done; sticky, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_prev_q <= 1'b0;
            sts_q <= 2'h0;
            en_q <= 2'h0;
            irq <= 1'b0;
        end else begin
            nmi_prev_q <= bus.nmi;
            if (do_write && awaddr_q == REG_ENABLE) en_q <= wdata_q[1:0];
            sts_q <= (sts_q & ~((do_write && awaddr_q == REG_CLEAR) ? wdata_q[1:0] : 2'h0))
                | {io_done, bus.nmi && !nmi_prev_q}; // [RQ15]
            irq <= |(sts_q & en_q);
        end
    end

    // ==========================================================
    // AXI4-Lite read, one cycle after the address is taken
    assign s_arready = !s_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= 2'h0;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp <= 2'h0;
            case (s_araddr)
                REG_RESULT: s_rdata <= {23'h0, state_q != NSH_IDLE, rdata_q}; // [RQ16]
                REG_STATUS: s_rdata <= {30'h0, sts_q};
                REG_ENABLE: s_rdata <= {30'h0, en_q};
                default: s_rdata <= 32'h0000_0000;
            endcase
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
        end
    end
endmodule : nsc_host

//--- nsc_assertions.sv
// Checker: properties on the port cycles and NMI level between the two ends
`timescale 1ns/10ps
module nsc_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic io_req,
    input wire logic io_write,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_ack,
    input wire logic [7:0] io_rdata,
    input wire logic nmi
);
    // ==========================================================
    // Shadow of what the processor wrote, taken at the request edge
    logic [3:0] ctrl_q;
    logic mask_q;
    logic rd61_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= nsc_pkg::NSC_CTRL_RESET;
        end else if (io_req && io_write && io_addr == nsc_pkg::NSC_PORT_STATUS) begin
            ctrl_q <= io_wdata[3:0];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= nsc_pkg::NSC_MASK_RESET;
        end else if (io_req && io_write && io_addr == nsc_pkg::NSC_PORT_MASK) begin
            mask_q <= io_wdata[nsc_pkg::NSC_BIT_MASK];
        end
    end
    always_ff @(posedge aclk) begin
        rd61_q <= aresetn && io_req && !io_write && io_addr == nsc_pkg::NSC_PORT_STATUS;
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence rd61_s;
        io_req && !io_write && io_addr == nsc_pkg::NSC_PORT_STATUS;
    endsequence
    // Four cycles covers the lag of the device's registered nmi output
    sequence open_s;
        !mask_q [*4];
    endsequence
    ack_after_req_a: assert property (io_req |=> io_ack)
        else $error("port request not answered");
    ack_cause_a: assert property (io_ack |-> $past(io_req))
        else $error("port answer without request");
    ctrl_readback_a: assert property (rd61_s |=> io_rdata[3:0] == ctrl_q)
        else $error("control bits read back wrong");
    serr_cleared_a: assert property (rd61_s ##0 ctrl_q[2] |=> !io_rdata[7])
        else $error("system error status not held clear");
    chk_cleared_a: assert property (rd61_s ##0 ctrl_q[3] |=> !io_rdata[6])
        else $error("channel check status not held clear");
    mask_read_a: assert property (io_req && !io_write
        && io_addr == nsc_pkg::NSC_PORT_MASK |=> io_rdata == 8'h00)
        else $error("mask port read returned data");
    masked_quiet_a: assert property (mask_q [*3] |-> !nmi)
        else $error("nmi high while masked");
    pending_level_a: assert property (open_s ##0 (rd61_q && io_ack
        && io_rdata[7:6] != 2'b00) |-> nmi)
        else $error("nmi low with a source pending");
endmodule : nsc_assertions

//--- nsc_tb.sv
// Testbench: both ends joined, host driven over AXI4-Lite, device pins driven
`timescale 1ns/10ps
module nmi_source_control_tb;
    logic aclk, aresetn, serr_pulse, chan_check, counter2_out, refresh_done;
    logic speaker_out, counter2_gate, isa_forward, isa_forward_write, irq;
    logic rtc_chip_select_n, rtc_address_latch_strobe, fwd_wr, c2, tog, serr, chk_s;
    logic [6:0] rtc_standard_index, idx;
    logic [7:0] s_awaddr, s_araddr, r;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [31:0] s_wdata, s_rdata, v;
    logic [3:0] s_wstrb, ctrl;
    logic [1:0] s_bresp, s_rresp;
    int n_fail, num_checks, n_fwd, n_cs, n_ale, f, cs;
    int seed = 32'h9275b9f7;
    nsc_if u_if();
    nsc_device i_nsc_device (.aclk, .aresetn, .bus(u_if), .serr_pulse, .chan_check,
        .counter2_out, .refresh_done, .speaker_out, .counter2_gate, .rtc_standard_index,
        .isa_forward, .isa_forward_write, .rtc_chip_select_n, .rtc_address_latch_strobe);
    nsc_host i_nsc_host (.aclk, .aresetn, .bus(u_if), .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .irq);
    nsc_assertions i_nsc_assertions (.aclk, .aresetn, .io_req(u_if.io_req),
        .io_write(u_if.io_write), .io_addr(u_if.io_addr), .io_wdata(u_if.io_wdata),
        .io_ack(u_if.io_ack), .io_rdata(u_if.io_rdata), .nmi(u_if.nmi));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Sampled mid-cycle, where the registered pulses have settled
    always @(negedge aclk) begin
        if (isa_forward) begin
            n_fwd++;
            fwd_wr = isa_forward_write;
        end
        if (!rtc_chip_select_n) n_cs++;
        if (rtc_address_latch_strobe) n_ale++;
    end
    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w, b;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= 4'hF;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!b) begin
            @(negedge aclk);
            aw = s_awvalid && s_awready;
            w = s_wvalid && s_wready;
            b = s_bvalid;
            @(posedge aclk);
            if (aw) s_awvalid <= 1'b0;
            if (w) s_wvalid <= 1'b0;
        end
        s_bready <= 1'b0;
        // Lets registered side effects land before anyone looks
        repeat (3) @(negedge aclk);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        bit ar, rv;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (!rv) begin
            @(negedge aclk);
            ar = s_arvalid && s_arready;
            rv = s_rvalid;
            d = s_rdata;
            @(posedge aclk);
            if (ar) s_arvalid <= 1'b0;
        end
        s_rready <= 1'b0;
    endtask : axi_rd
    task automatic io(input bit wr, input logic [7:0] p, input logic [7:0] d,
        output logic [7:0] q);
        logic [31:0] st;
        axi_wr(nsc_pkg::NSC_REG_CMD, {8'h00, p, 7'h00, wr, d});
        st = 32'h0;
        while (st[1] !== 1'b1) axi_rd(nsc_pkg::NSC_REG_STATUS, st);
        axi_rd(nsc_pkg::NSC_REG_RESULT, st);
        q = st[7:0];
        axi_wr(nsc_pkg::NSC_REG_CLEAR, 32'h2);
    endtask : io
    task automatic kick(input int hold, input bit on_chk);
        @(posedge aclk);
        if (on_chk) chan_check <= 1'b1;
        else serr_pulse <= 1'b1;
        repeat (hold) @(posedge aclk);
        chan_check <= 1'b0;
        serr_pulse <= 1'b0;
        repeat (10) @(negedge aclk);
    endtask : kick
    function automatic logic [7:0] exp61();
        return {serr, chk_s, c2, tog, ctrl};
    endfunction : exp61
    // ==========================================================
    // Main sequence
    initial begin
        aresetn = 1'b0;
        {serr_pulse, chan_check, counter2_out, refresh_done} = 4'h0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
        {ctrl, c2, tog, serr, chk_s, idx} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        io(1'b0, 8'h61, 8'h00, r);
        chk(r, exp61());
        chk(u_if.nmi, 1'b0);
        for (int i = 0; i < 16; i++) begin
            ctrl = 4'(i);
            c2 = 1'($random(seed));
            @(posedge aclk);
            counter2_out <= c2;
            io(1'b1, 8'h61, {4'h0, ctrl}, r);
            io(1'b0, 8'h61, 8'h00, r);
            chk(r, exp61());
            chk(counter2_gate, ctrl[0]);
            chk(speaker_out, ctrl[1] & c2);
        end
        for (int i = 0; i < 2; i++) begin
            repeat (1 + ($random(seed) & 3)) begin
                @(posedge aclk);
                refresh_done <= 1'b1;
                @(posedge aclk);
                refresh_done <= 1'b0;
                tog = ~tog;
            end
            io(1'b0, 8'h61, 8'h00, r);
            chk(r, exp61());
        end
        idx = 7'($random(seed));
        f = n_fwd;
        cs = n_cs;
        io(1'b1, 8'h70, {1'b0, idx}, r);
        chk(rtc_standard_index, idx);
        io(1'b0, 8'h70, 8'h00, r);
        chk(r, 8'h00);
        chk(n_fwd, f + 2);
        chk(n_cs, cs + 1);
        chk(n_ale, n_cs);
        chk(fwd_wr, 1'b0);
        ctrl = 4'h0;
        io(1'b1, 8'h61, 8'h00, r);
        axi_wr(8'h10, 32'h1);
        // Pin filter needs the pulse to stand for two clocks
        kick(2, 1'b0);
        serr = 1'b1;
        chk(u_if.nmi, 1'b1);
        chk(irq, 1'b1);
        kick(4, 1'b1);
        chk_s = 1'b1;
        io(1'b0, 8'h61, 8'h00, r);
        chk(r, exp61());
        axi_wr(8'h10, 32'h0);
        chk(irq, 1'b0);
        axi_wr(8'h0C, 32'h1);
        axi_wr(8'h10, 32'h1);
        chk(irq, 1'b0);
        io(1'b1, 8'h70, {1'b1, idx}, r);
        chk(u_if.nmi, 1'b0);
        chk(rtc_standard_index, idx);
        io(1'b1, 8'h70, {1'b0, idx}, r);
        chk(u_if.nmi, 1'b1);
        chk(irq, 1'b1);
        ctrl = 4'h4;
        serr = 1'b0;
        io(1'b1, 8'h61, 8'h04, r);
        kick(2, 1'b0);
        io(1'b0, 8'h61, 8'h00, r);
        chk(r, exp61());
        chk(u_if.nmi, 1'b1);
        ctrl = 4'hC;
        chk_s = 1'b0;
        io(1'b1, 8'h61, 8'h0C, r);
        chk(u_if.nmi, 1'b0);
        ctrl = 4'h0;
        io(1'b1, 8'h61, 8'h00, r);
        io(1'b0, 8'h61, 8'h00, r);
        chk(r, exp61());
        f = n_fwd;
        io(1'b0, 8'h80, 8'h00, r);
        chk(r, 8'h00);
        chk(n_fwd, f);
        axi_rd(8'h1C, v);
        chk(v, 32'h0);
        end_of_test();
    end
    // Far longer than the roughly one thousand cycles the sequence needs
    initial begin
        #300000;
        n_fail++;
        end_of_test();
    end
endmodule : nmi_source_control_tb
